// File: bench/adpi_chk.sv
// Port checker for the packet framer
`timescale 1ns/100ps
module adpi_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ack_en,
    input wire logic hb_en,
    input wire logic rx_ready_q,
    input adpi_pkg::adpi_byte_s anc_q,
    input wire logic anc_ready,
    input wire logic ins_done,
    input adpi_pkg::adpi_byte_s tx_q,
    input wire logic tx_ready,
    input wire logic dat_en,
    input wire logic [2:0] dat_pair,
    input wire logic [15:0] nonpcm_ch_q,
    input wire logic [4:0] data_type_q
);
    // Byte index inside the current 32-byte tx packet
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (tx_q.valid && tx_ready) begin
            cnt_d = tx_q.last ? 5'h00 : cnt_q + 5'h01;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_TX_HEAD: assert property (
        tx_q.valid && cnt_q == 5'h00 |-> tx_q.data inside {8'h38, 8'h31})
        else $error("tx packet type byte wrong");
    AST_TX_LAST: assert property (
        tx_q.valid |-> tx_q.last == (cnt_q == 5'h1f))
        else $error("tx last flag misplaced");
    AST_ACK_SOON: assert property (
        ins_done && ack_en && !tx_q.valid && cnt_q == 5'h00 |-> ##[1:3] tx_q.valid)
        else $error("ack not started after placement");
    AST_TX_QUIET: assert property (
        !ack_en && !hb_en && cnt_q == 5'h00 && !tx_q.valid |=> !tx_q.valid)
        else $error("tx packet while both disabled");
    AST_ANC_HOLD: assert property (
        anc_q.valid && !anc_ready |=> anc_q.valid && $stable(anc_q.data))
        else $error("payload byte dropped before taken");
    AST_RX_STALL: assert property (
        anc_q.valid |-> !rx_ready_q)
        else $error("rx ready while payload pending");
    AST_PAIR: assert property (
        dat_en && $past(dat_en) && $stable(dat_pair)
        |-> nonpcm_ch_q == (16'h0003 << {dat_pair, 1'b0}))
        else $error("wrong channel pair flagged");
    AST_DTYPE: assert property (
        dat_en |=> data_type_q == adpi_pkg::DTYPE_UNKNOWN)
        else $error("data type not unknown");
    COV_ACK: cover property (ins_done && ack_en ##[1:3] tx_q.valid);
    COV_HB: cover property (tx_q.valid && !ack_en && cnt_q == 5'h00);
    COV_STALL: cover property (anc_q.valid && !anc_ready);
endmodule
bind adpi_framer adpi_chk i_chk (.ref_clk, .rstn, .ack_en, .hb_en, .rx_ready_q, .anc_q,
    .anc_ready, .ins_done, .tx_q, .tx_ready, .dat_en, .dat_pair, .nonpcm_ch_q, .data_type_q);

// File: bench/adpi_sender.sv
// Remote controller model: sends insertion packets, takes ack and heartbeat bytes
`timescale 1ns/100ps
module adpi_sender (
    input wire logic ref_clk,
    input wire logic rx_ready_q,
    input adpi_pkg::adpi_byte_s tx_q,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic tx_ready
);
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    // Slow mode stalls every other cycle
    always @(posedge ref_clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_q.valid && tx_ready) begin
            got.push_back(tx_q.data);
        end
    end
    task automatic send(input logic [15:0] line, input int n, input logic [31:0] typ,
        output bit ok);
        adpi_pkg::adpi_hdr_s h;
        int m;
        int k;
        m = (n > 255) ? 255 : n;
        h = '{32'h1234abcd, 16'(m), line, 8'h07, 8'h41, 16'(m + 16), typ};
        ok = 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < m + 16; i++) begin
            rx_valid <= 1'b1;
            rx_data <= (i < 16) ? h[8*i +: 8] : 8'(i - 16) ^ 8'h5a;
            rx_last <= (i == m + 15);
            k = 0;
            do begin
                @(negedge ref_clk);
                k++;
            end while (!rx_ready_q && k < 300);
            @(posedge ref_clk);
            if (k >= 300) begin
                ok = 1'b0;
                break;
            end
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        // Released line shows no stale byte
        rx_data <= ~rx_data;
    endtask
endmodule

// File: bench/adpi_tb.sv
// Self-checking testbench for the packet framer
`timescale 1ns/100ps
module testbench;
    localparam longint HB = 50;
    logic ref_clk, rstn, ack_en, hb_en, anc_ready, ins_done, dat_en, slow, tx_ready;
    logic rx_valid, rx_last, rx_ready_q;
    logic [7:0] rx_data, anc_did_q, anc_sdid_q;
    logic [15:0] default_line, anc_line_q, nonpcm_ch_q;
    logic [2:0] dat_pair;
    logic [4:0] data_type_q;
    adpi_pkg::adpi_byte_s anc_q, tx_q;
    adpi_pkg::adpi_hdr_s h;
    logic [8:0] anc_got[$];
    int errors, total_checks, k;
    bit ok;
    typedef struct {logic [15:0] line; int n; logic s; logic [15:0] used;} adpi_row_s;
    adpi_row_s rows[4] = '{'{16'h0000, 1, 0, 16'h0015}, '{16'h000a, 4, 1, 16'h000a},
        '{16'h0000, 255, 0, 16'h0015}, '{16'hffff, 2, 1, 16'hffff}};
    adpi_framer #(.HB_CYCLES(HB)) i_dut (.ref_clk, .rstn, .ack_en, .hb_en, .default_line,
        .rx_valid, .rx_data, .rx_last, .rx_ready_q, .anc_q, .anc_did_q, .anc_sdid_q,
        .anc_line_q, .anc_ready, .ins_done, .tx_q, .tx_ready, .dat_en, .dat_pair,
        .nonpcm_ch_q, .data_type_q);
    adpi_sender i_snd (.ref_clk, .rx_ready_q, .tx_q, .slow, .rx_valid, .rx_data, .rx_last,
        .tx_ready);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Consumer stalls every other cycle
    always @(posedge ref_clk) begin
        anc_ready <= ~anc_ready;
        if (anc_q.valid && anc_ready) begin
            anc_got.push_back({anc_q.last, anc_q.data});
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_tx(input int n, input int lim);
        k = 0;
        while (i_snd.got.size() < n && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
        if (i_snd.got.size() < n) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic snd(input logic [15:0] line, input int n, input logic [31:0] typ);
        i_snd.got.delete();
        anc_got.delete();
        i_snd.send(line, n, typ, ok);
        if (!ok) begin
            errors++;
            end_of_test();
        end
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic pulse();
        ins_done <= 1'b1;
        @(posedge ref_clk);
        ins_done <= 1'b0;
    endtask
    function automatic logic [7:0] exp_b(input int i);
        return (i < 16) ? h[8*i +: 8] : 8'h00;
    endfunction
    initial begin
        {rstn, ack_en, hb_en, anc_ready, ins_done, dat_en, slow, errors, total_checks} = '0;
        default_line = 16'h0015;
        dat_pair = 3'h0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        chk({tx_q.valid, anc_q.valid, rx_ready_q}, 32'h0);
        ack_en <= 1'b1;
        foreach (rows[r]) begin
            slow <= rows[r].s;
            snd(rows[r].line, rows[r].n, adpi_pkg::INS_TYPE);
            chk(anc_got.size(), rows[r].n);
            foreach (anc_got[i]) chk(anc_got[i], {i == rows[r].n - 1, i[7:0] ^ 8'h5a});
            chk({anc_did_q, anc_sdid_q, anc_line_q}, {16'h4107, rows[r].used});
            chk(i_snd.got.size(), 0);
            pulse();
            wait_tx(32, 200);
            repeat (40) @(posedge ref_clk);
            chk(i_snd.got.size(), 32);
            h = '{32'h1234abcd, 16'(rows[r].n), rows[r].used, 8'h07, 8'h41,
                16'(rows[r].n + 16), adpi_pkg::ACK_TYPE};
            foreach (i_snd.got[i]) chk(i_snd.got[i], exp_b(i));
        end
        ack_en <= 1'b0;
        slow <= 1'b0;
        snd(16'h0000, 3, adpi_pkg::INS_TYPE);
        pulse();
        repeat (40) @(posedge ref_clk);
        chk(i_snd.got.size(), 0);
        snd(16'h0000, 3, ~adpi_pkg::INS_TYPE);
        chk(anc_got.size(), 0);
        h = '0;
        h.ptype = adpi_pkg::HB_TYPE;
        hb_en <= 1'b1;
        wait_tx(64, 4 * HB);
        hb_en <= 1'b0;
        chk(k > HB && k < 3 * HB, 1);
        foreach (i_snd.got[i]) chk(i_snd.got[i], exp_b(i % 32));
        dat_en <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            dat_pair <= p[2:0];
            repeat (3) @(posedge ref_clk);
            chk({nonpcm_ch_q, 11'h0, data_type_q}, {16'h3 << (2 * p), 16'h0});
        end
        dat_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({tx_q.valid, anc_q.valid, rx_ready_q, nonpcm_ch_q}, 32'h0);
        end_of_test();
    end
endmodule

// File: design/adpi_framer.sv
// Ancillary data insertion packet framer with acknowledge and heartbeat
// Behaviour
// - One acknowledge per insertion, after placement
// - Heartbeat packet every two seconds when enabled
// - Insertion packet header field layout fixed
// - Line zero selects the software default line
// - Acknowledge echoes header, reports line actually used
// - Data audio pair flagged non-PCM, unknown type
`timescale 1ns/100ps
module adpi_framer #(
    parameter longint HB_CYCLES = adpi_pkg::HB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ack_en,
    input wire logic hb_en,
    input wire logic [15:0] default_line,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready_q,
    output adpi_pkg::adpi_byte_s anc_q,
    output logic [7:0] anc_did_q,
    output logic [7:0] anc_sdid_q,
    output logic [15:0] anc_line_q,
    input wire logic anc_ready,
    input wire logic ins_done,
    output adpi_pkg::adpi_byte_s tx_q,
    input wire logic tx_ready,
    input wire logic dat_en,
    input wire logic [2:0] dat_pair,
    output logic [15:0] nonpcm_ch_q,
    output logic [4:0] data_type_q
);
    ////////////////////////////////////////////////////////////////////////////
    adpi_pkg::adpi_state_e st_q, st_d;
    adpi_pkg::adpi_hdr_s hdr_q, hdr_d;
    logic [127:0] hraw_q, hraw_d;
    logic [15:0] cnt_q, cnt_d;
    logic rx_ready_d;
    adpi_pkg::adpi_byte_s anc_d;
    logic [15:0] anc_line_d;
    logic [31:0] hb_cnt_q, hb_cnt_d;
    logic hb_pend_q, hb_pend_d;
    logic ser_start;
    logic [255:0] ser_pkt;
    logic ser_busy;
    logic take;
    adpi_pkg::adpi_hdr_s hparse;

    assign take = rx_valid && rx_ready_q;
    assign hparse = adpi_pkg::adpi_hdr_s'({rx_data, hraw_q[127:8]});

    ////////////////////////////////////////////////////////////////////////////
    // Heartbeat interval; a tick in the same cycle as the send keeps the flag
    always_comb begin
        hb_cnt_d = hb_cnt_q;
        hb_pend_d = hb_pend_q;
        if (!hb_en) begin
            hb_cnt_d = 32'h0000_0000;
            hb_pend_d = 1'b0;
        end else begin
            if (st_q == adpi_pkg::ST_HB) begin
                hb_pend_d = 1'b0;
            end
            if (hb_cnt_q == 32'(HB_CYCLES - 1)) begin
                hb_cnt_d = 32'h0000_0000;
                hb_pend_d = 1'b1;
            end else begin
                hb_cnt_d = hb_cnt_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        hdr_d = hdr_q;
        hraw_d = hraw_q;
        cnt_d = cnt_q;
        anc_d = anc_q;
        anc_line_d = anc_line_q;
        ser_start = 1'b0;
        ser_pkt = '0;
        if (anc_q.valid && anc_ready) begin
            anc_d = '{valid: 1'b0, data: 8'h00, last: 1'b0};
        end
        case (st_q)
            adpi_pkg::ST_IDLE: begin
                cnt_d = 16'h0000;
                if (hb_pend_q && !ser_busy) begin
                    st_d = adpi_pkg::ST_HB;
                end else if (rx_valid) begin
                    st_d = adpi_pkg::ST_HDR;
                end
            end
            adpi_pkg::ST_HDR: begin
                if (take) begin
                    hraw_d = {rx_data, hraw_q[127:8]};
                    cnt_d = cnt_q + 16'h0001;
                    if (cnt_q == 16'(adpi_pkg::HDR_BYTES - 1)) begin
                        hdr_d = hparse;
                        cnt_d = 16'h0000;
                        if (hparse.line == adpi_pkg::LINE_USE_DEFAULT) begin
                            anc_line_d = default_line;
                        end else begin
                            anc_line_d = hparse.line;
                        end
                        // Wrong type, empty payload or early end: discard
                        if (hparse.ptype != adpi_pkg::INS_TYPE ||
                            hparse.pay_size == 16'h0000) begin
                            st_d = rx_last ? adpi_pkg::ST_IDLE : adpi_pkg::ST_DROP;
                        end else if (rx_last) begin
                            st_d = adpi_pkg::ST_IDLE;
                        end else begin
                            st_d = adpi_pkg::ST_PAY;
                        end
                    end else if (rx_last) begin
                        st_d = adpi_pkg::ST_IDLE;
                    end
                end
            end
            adpi_pkg::ST_PAY: begin
                if (take) begin
                    cnt_d = cnt_q + 16'h0001;
                    anc_d.valid = 1'b1;
                    anc_d.data = rx_data;
                    anc_d.last = (cnt_d == hdr_q.pay_size) || rx_last;
                    if (anc_d.last) begin
                        // Anything after the declared payload is dropped
                        st_d = rx_last ? adpi_pkg::ST_WAIT : adpi_pkg::ST_DROP;
                    end
                end
            end
            adpi_pkg::ST_DROP: begin
                if (take && rx_last) begin
                    st_d = (cnt_q != 16'h0000) ? adpi_pkg::ST_WAIT : adpi_pkg::ST_IDLE;
                end
            end
            adpi_pkg::ST_WAIT: begin
                if (ins_done) begin
                    st_d = (ack_en) ? adpi_pkg::ST_ACK : adpi_pkg::ST_IDLE;
                end
            end
            adpi_pkg::ST_ACK: begin
                if (!ser_busy) begin
                    ser_start = 1'b1;
                    ser_pkt = {128'h0, hdr_q.user_id, hdr_q.pay_size, anc_line_q,
                        hdr_q.sdid, hdr_q.did, hdr_q.pkt_size, adpi_pkg::ACK_TYPE};
                    st_d = adpi_pkg::ST_IDLE;
                end
            end
            adpi_pkg::ST_HB: begin
                ser_start = 1'b1;
                ser_pkt = {224'h0, adpi_pkg::HB_TYPE};
                st_d = adpi_pkg::ST_IDLE;
            end
            default: begin
                st_d = adpi_pkg::ST_IDLE;
            end
        endcase
        // Ready is registered, so payload moves at most one byte every other cycle
        // A payload byte still pending holds ready low in the drop state too
        rx_ready_d = (st_d == adpi_pkg::ST_HDR) ||
            (((st_d == adpi_pkg::ST_DROP) || (st_d == adpi_pkg::ST_PAY)) && !anc_d.valid);
        if (st_q == adpi_pkg::ST_DROP && st_d != adpi_pkg::ST_DROP) begin
            rx_ready_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= adpi_pkg::ST_IDLE;
            hdr_q <= '0;
            hraw_q <= '0;
            cnt_q <= 16'h0000;
            rx_ready_q <= 1'b0;
            anc_q <= '0;
            anc_line_q <= 16'h0000;
            hb_cnt_q <= 32'h0000_0000;
            hb_pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            hdr_q <= hdr_d;
            hraw_q <= hraw_d;
            cnt_q <= cnt_d;
            rx_ready_q <= rx_ready_d;
            anc_q <= anc_d;
            anc_line_q <= anc_line_d;
            hb_cnt_q <= hb_cnt_d;
            hb_pend_q <= hb_pend_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            anc_did_q <= 8'h00;
            anc_sdid_q <= 8'h00;
        end else begin
            anc_did_q <= hdr_q.did;
            anc_sdid_q <= hdr_q.sdid;
        end
    end

    adpi_tx_ser u_ser (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(ser_start),
        .pkt(ser_pkt),
        .tx_ready(tx_ready),
        .tx_q(tx_q),
        .busy_q(ser_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pair index selects channels 2k,2k+1, so an odd boundary cannot be chosen
    generate
        for (genvar p = 0; p < adpi_pkg::AUD_PAIRS; p++) begin : g_pair
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    nonpcm_ch_q[2*p +: 2] <= 2'h0;
                end else begin
                    nonpcm_ch_q[2*p +: 2] <= {2{dat_en && (dat_pair == 3'(p))}};
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            data_type_q <= adpi_pkg::DTYPE_UNKNOWN;
        end else begin
            data_type_q <= adpi_pkg::DTYPE_UNKNOWN;
        end
    end
endmodule

// File: design/adpi_pkg.sv
// Constants and types shared by the ancillary data packet framer
package adpi_pkg;
    // Packet type codes
    localparam logic [31:0] INS_TYPE = 32'hf5ab02ed;
    localparam logic [31:0] ACK_TYPE = 32'hac73b938;
    localparam logic [31:0] HB_TYPE = 32'h20120831;
    // Byte positions of the insertion header (little-endian fields)
    localparam int HDR_BYTES = 16;
    localparam int TX_BYTES = 32;
    localparam int OFS_TYPE = 0;
    localparam int OFS_PKT_SIZE = 4;
    localparam int OFS_DID = 6;
    localparam int OFS_SDID = 7;
    localparam int OFS_LINE = 8;
    localparam int OFS_PAY_SIZE = 10;
    localparam int OFS_USER_ID = 12;
    localparam logic [15:0] LINE_USE_DEFAULT = 16'h0000;
    // Timing
    localparam longint CLK_HZ = 25000000;
    localparam longint HB_PERIOD_S = 2;
    localparam longint HB_CYCLES = HB_PERIOD_S * CLK_HZ;
    // Embedded audio carrying data
    localparam int AUD_PAIRS = 8;
    localparam logic [4:0] DTYPE_UNKNOWN = 5'h00;

    typedef struct packed {
        logic [31:0] user_id;
        logic [15:0] pay_size;
        logic [15:0] line;
        logic [7:0] sdid;
        logic [7:0] did;
        logic [15:0] pkt_size;
        logic [31:0] ptype;
    } adpi_hdr_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } adpi_byte_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_PAY = 3'b011,
        ST_WAIT = 3'b010,
        ST_ACK = 3'b110,
        ST_HB = 3'b111,
        ST_DROP = 3'b101
    } adpi_state_e;
endpackage

// File: design/adpi_tx_ser.sv
// Byte serializer for the 32-byte acknowledgement and heartbeat packets
`timescale 1ns/100ps
module adpi_tx_ser (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [255:0] pkt,
    input wire logic tx_ready,
    output adpi_pkg::adpi_byte_s tx_q,
    output logic busy_q
);
    logic [255:0] sh_q, sh_d;
    logic [4:0] cnt_q, cnt_d;
    logic busy_d;
    adpi_pkg::adpi_byte_s tx_d;

    always_comb begin
        sh_d = sh_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        tx_d = tx_q;
        if (!busy_q && start) begin
            // Byte 0 goes out first
            sh_d = pkt >> 8;
            cnt_d = 5'h00;
            busy_d = 1'b1;
            tx_d = '{valid: 1'b1, data: pkt[7:0], last: 1'b0};
        end else if (busy_q && tx_ready) begin
            if (tx_q.last) begin
                busy_d = 1'b0;
                tx_d = '{valid: 1'b0, data: 8'h00, last: 1'b0};
            end else begin
                cnt_d = cnt_q + 5'h01;
                tx_d.data = sh_q[7:0];
                tx_d.last = (cnt_q == 5'(adpi_pkg::TX_BYTES - 2));
                sh_d = sh_q >> 8;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sh_q <= '0;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            tx_q <= '0;
        end else begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            tx_q <= tx_d;
        end
    end
endmodule
